// File: rtl/sfes_defs.vh
// Opcodes, field positions, widths and timing constants of the erase sequencer
`ifndef SFES_DEFS_VH
`define SFES_DEFS_VH

// Command opcodes
`define SFES_OP_WRITE_ENABLE  8'h06
`define SFES_OP_READ_STATUS   8'h05
`define SFES_OP_ACTIVE_STATUS 8'h25
`define SFES_OP_SUSPEND       8'h75
`define SFES_OP_PAGE_ERASE_A  8'h81
`define SFES_OP_PAGE_ERASE_B  8'hdb
`define SFES_OP_BLOCK_4K      8'h20
`define SFES_OP_BLOCK_32K     8'h52
`define SFES_OP_BLOCK_64K     8'hd8
`define SFES_OP_CHIP_ERASE_A  8'h60
`define SFES_OP_CHIP_ERASE_B  8'hc7

// Erase kind codes on the array interface
`define SFES_KIND_PAGE     3'h0
`define SFES_KIND_BLK4K    3'h1
`define SFES_KIND_BLK32K   3'h2
`define SFES_KIND_BLK64K   3'h3
`define SFES_KIND_CHIP     3'h4

// Frame layout: opcode byte plus three address bytes
`define SFES_ADDR_BYTES    3'h3
`define SFES_FULL_BYTES    3'h4

// Status register one field positions
`define SFES_SR1_BUSY_BIT  0
`define SFES_SR1_WEL_BIT   1

// Region base masks, low bits ignored per region size
`define SFES_MASK_4K       24'hfff000
`define SFES_MASK_32K      24'hff8000
`define SFES_MASK_64K      24'hff0000
`define SFES_PAGE_LO       8
`define SFES_PAGE_HI       19

// Timing: clock period and self-timed erase durations
`define SFES_CLK_PERIOD_NS       100
`define SFES_PAGE_ERASE_TIME_US  2000
`define SFES_BLOCK_ERASE_TIME_US 100000
`define SFES_CHIP_ERASE_TIME_US  5000000

`endif

// File: rtl/sfes_top.v
// Erase command sequencer of a serial flash, SPI slave side
`timescale 1ns/100ps
`include "sfes_defs.vh"
// Operation
// (R1) Erase accepted only when the write enable latch was set by opcode 06h.
// (R2) Erase with latch clear is ignored: no array change, no busy.
// (R3) Opcodes 20h, 52h, D8h erase a 4, 32 or 64 kB region.
// (R4) A completed erase leaves its whole region at logic one.
// (R5) Block erase frame: opcode then 24 address bits, MSB first, no data.
// (R6) Low address bits 11..0, 14..0 or 15..0 ignored by region size.
// (R7) Block erase starts at chip select rise and runs self-timed.
// (R8) Chip select rising off a byte boundary aborts any erase.
// (R9) Page or block erase aborts if fewer than three address bytes came.
// (R10) Protected target: no erase, back to idle at chip select rise.
// (R11) Block erase abort of any kind clears the write enable latch.
// (R12) Busy flag, status bit 0, stays set until the erase finishes.
// (R13) Write enable latch cleared before a successful erase completes.
// (R14) Host should poll status register one for completion.
// (R15) After opcode 25h the busy flag is driven on SO every cycle.
// (R16) Host treats SO falling from one to zero as completion.
// (R17) A failed erase sets both erase and program error flags.
// (R18) Chip erase opcodes 60h and C7h behave identically.
// (R19) Chip erase is the opcode alone; starts at chip select rise.
// (R20) Chip erase refused if any region is protected or locked.
// (R21) Chip erase abort by boundary or protection clears the latch.
// (R22) Suspend opcode 75h is ignored while a chip erase runs.
// (R23) Page erase uses 81h or DBh with a three byte address.
// (R24) Page erase: bits 19..8 pick the page, others ignored.
// (R25) Page erase starts at chip select rise, busy for its duration.
module sfes_top #(
  // Scale per microsecond first so the chip erase count stays inside 32 bits
  parameter [31:0] PAGE_ERASE_CYCLES  = `SFES_PAGE_ERASE_TIME_US * (1000 / `SFES_CLK_PERIOD_NS),
  parameter [31:0] BLOCK_ERASE_CYCLES = `SFES_BLOCK_ERASE_TIME_US * (1000 / `SFES_CLK_PERIOD_NS),
  parameter [31:0] CHIP_ERASE_CYCLES  = `SFES_CHIP_ERASE_TIME_US * (1000 / `SFES_CLK_PERIOD_NS)
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        RST,
  // SPI pins
  input  wire        CS_N,
  input  wire        SCK,
  input  wire        SI,
  output reg         SO,
  output reg         SO_OE,
  // Protection inputs
  input  wire [2:0]  BLOCK_PROTECT_FIELD,
  input  wire        INDIVIDUAL_LOCK_SELECT,
  input  wire        ANY_BLOCK_LOCKED,
  input  wire        REGION_PROTECTED,
  // Array interface
  input  wire        ERASE_FAIL,
  output reg  [23:0] CMD_ADDR,
  output reg         ERASE_START,
  output reg  [2:0]  ERASE_KIND,
  output reg  [23:0] ERASE_BASE,
  output reg         ERASE_DONE,
  // Status flags
  output reg         READY_BUSY_FLAG,
  output reg         WRITE_ENABLE_LATCH,
  output reg         ERASE_ERROR_FLAG,
  output reg         PROGRAM_ERROR_FLAG
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_ERASE = 1'b1;

  // Synchroniser stages for the pins
  reg        cs_n_m_q;
  reg        cs_n_s_q;
  reg        cs_n_p_q;
  reg        sck_m_q;
  reg        sck_s_q;
  reg        sck_p_q;
  reg        si_m_q;
  reg        si_s_q;

  // Frame receiver state
  reg  [6:0] shift_q;
  reg  [2:0] bit_q;
  reg  [2:0] byte_q;
  reg  [7:0] opc_q;

  // Sequencer state
  reg        st_q;
  reg [31:0] cnt_q;
  reg        chip_run_q;
  reg  [7:0] out_q;

  wire       sck_rise;
  wire       sck_fall;
  wire       cs_rise;
  wire       sel;
  wire [7:0] rx_byte;
  wire       op_page;
  wire       op_blk4;
  wire       op_blk32;
  wire       op_blk64;
  wire       op_chip;
  wire       op_erase;
  wire       whole;
  wire       addr_ok;
  wire       chip_prot;
  wire       prot;
  wire [7:0] status_one;
  wire       mode_status;
  wire       mode_active;

  reg  [2:0]  kind_d;
  reg  [23:0] base_d;
  reg  [31:0] dur_d;

  // Two flip-flop synchronisers, third stage only for edge finding
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      cs_n_m_q <= 1'b1;
      cs_n_s_q <= 1'b1;
      cs_n_p_q <= 1'b1;
      sck_m_q  <= 1'b0;
      sck_s_q  <= 1'b0;
      sck_p_q  <= 1'b0;
      si_m_q   <= 1'b0;
      si_s_q   <= 1'b0;
    end else begin
      cs_n_m_q <= CS_N;
      cs_n_s_q <= cs_n_m_q;
      cs_n_p_q <= cs_n_s_q;
      sck_m_q  <= SCK;
      sck_s_q  <= sck_m_q;
      sck_p_q  <= sck_s_q;
      si_m_q   <= SI;
      si_s_q   <= si_m_q;
    end
  end

  // Edge events of the link
  assign sck_rise = sck_s_q & ~sck_p_q;
  assign sck_fall = ~sck_s_q & sck_p_q;
  assign cs_rise  = cs_n_s_q & ~cs_n_p_q;
  assign sel      = ~cs_n_s_q;
  assign rx_byte  = {shift_q, si_s_q};

  // Frame receiver: MSB first on SCK rising edges
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      shift_q  <= 7'h00;
      bit_q    <= 3'h0;
      byte_q   <= 3'h0;
      opc_q    <= 8'h00;
      CMD_ADDR <= 24'h000000;
    end else if (!sel) begin
      bit_q  <= 3'h0;
      byte_q <= 3'h0;
    end else if (sck_rise) begin
      shift_q <= rx_byte[6:0];
      bit_q   <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        if (byte_q != `SFES_FULL_BYTES + 3'h1)
          byte_q <= byte_q + 3'h1;
        if (byte_q == 3'h0)
          opc_q <= rx_byte;
        else if (byte_q <= `SFES_ADDR_BYTES)
          CMD_ADDR <= {CMD_ADDR[15:0], rx_byte}; // R5
      end
    end
  end

  // Opcode decode
  assign op_page  = (opc_q == `SFES_OP_PAGE_ERASE_A) | (opc_q == `SFES_OP_PAGE_ERASE_B); // R23
  assign op_blk4  = (opc_q == `SFES_OP_BLOCK_4K); // R3
  assign op_blk32 = (opc_q == `SFES_OP_BLOCK_32K); // R3
  assign op_blk64 = (opc_q == `SFES_OP_BLOCK_64K); // R3
  assign op_chip  = (opc_q == `SFES_OP_CHIP_ERASE_A) | (opc_q == `SFES_OP_CHIP_ERASE_B); // R18
  assign op_erase = op_page | op_blk4 | op_blk32 | op_blk64 | op_chip;

  // Frame checks at chip select rise
  assign whole     = (bit_q == 3'h0); // R8
  assign addr_ok   = op_chip | (byte_q >= `SFES_FULL_BYTES); // R9
  assign chip_prot = (BLOCK_PROTECT_FIELD != 3'h0) | (INDIVIDUAL_LOCK_SELECT & ANY_BLOCK_LOCKED); // R20
  assign prot      = op_chip ? chip_prot : REGION_PROTECTED; // R10

  // Region kind, base and duration for the decoded erase
  always @* begin
    kind_d = `SFES_KIND_CHIP;
    base_d = 24'h000000;
    dur_d  = CHIP_ERASE_CYCLES; // R19
    if (op_page) begin
      kind_d = `SFES_KIND_PAGE;
      base_d = {4'h0, CMD_ADDR[`SFES_PAGE_HI:`SFES_PAGE_LO], 8'h00}; // R24
      dur_d  = PAGE_ERASE_CYCLES; // R25
    end else if (op_blk4) begin
      kind_d = `SFES_KIND_BLK4K;
      base_d = CMD_ADDR & `SFES_MASK_4K; // R6
      dur_d  = BLOCK_ERASE_CYCLES; // R7
    end else if (op_blk32) begin
      kind_d = `SFES_KIND_BLK32K;
      base_d = CMD_ADDR & `SFES_MASK_32K; // R6
      dur_d  = BLOCK_ERASE_CYCLES; // R7
    end else if (op_blk64) begin
      kind_d = `SFES_KIND_BLK64K;
      base_d = CMD_ADDR & `SFES_MASK_64K; // R6
      dur_d  = BLOCK_ERASE_CYCLES; // R7
    end
  end

  // Sequencer: latch handling, launch, abort and self-timed erase
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q               <= ST_IDLE;
      cnt_q              <= 32'h00000000;
      chip_run_q         <= 1'b0;
      ERASE_START        <= 1'b0;
      ERASE_DONE         <= 1'b0;
      ERASE_KIND         <= `SFES_KIND_PAGE;
      ERASE_BASE         <= 24'h000000;
      READY_BUSY_FLAG    <= 1'b0;
      WRITE_ENABLE_LATCH <= 1'b0;
      ERASE_ERROR_FLAG   <= 1'b0;
      PROGRAM_ERROR_FLAG <= 1'b0;
    end else begin
      ERASE_START <= 1'b0;
      ERASE_DONE  <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (cs_rise && byte_q != 3'h0) begin
            if (opc_q == `SFES_OP_WRITE_ENABLE) begin
              if (whole)
                WRITE_ENABLE_LATCH <= 1'b1; // R1
            end else if (op_erase && WRITE_ENABLE_LATCH) begin // R1 R2
              if (!whole || !addr_ok || prot) begin
                WRITE_ENABLE_LATCH <= 1'b0; // R11 R21
              end else begin
                st_q               <= ST_ERASE;
                cnt_q              <= dur_d - 32'h00000001;
                chip_run_q         <= op_chip;
                ERASE_START        <= 1'b1; // R4
                ERASE_KIND         <= kind_d;
                ERASE_BASE         <= base_d;
                READY_BUSY_FLAG    <= 1'b1; // R12
                WRITE_ENABLE_LATCH <= 1'b0; // R13
                ERASE_ERROR_FLAG   <= 1'b0;
                PROGRAM_ERROR_FLAG <= 1'b0;
              end
            end
          end
        end
        ST_ERASE: begin
          // Commands other than status are not acted on while busy; a
          // suspend opcode during a chip erase has no effect
          if (cs_rise && chip_run_q && opc_q == `SFES_OP_SUSPEND)
            chip_run_q <= 1'b1; // R22
          if (cnt_q == 32'h00000000) begin
            st_q            <= ST_IDLE;
            chip_run_q      <= 1'b0;
            ERASE_DONE      <= 1'b1; // R4
            READY_BUSY_FLAG <= 1'b0; // R12
            if (ERASE_FAIL) begin
              ERASE_ERROR_FLAG   <= 1'b1; // R17
              PROGRAM_ERROR_FLAG <= 1'b1; // R17
            end
          end else begin
            cnt_q <= cnt_q - 32'h00000001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Status byte and read-back modes
  assign status_one  = {6'h00, WRITE_ENABLE_LATCH, READY_BUSY_FLAG};
  assign mode_status = sel & (byte_q != 3'h0) & (opc_q == `SFES_OP_READ_STATUS);
  assign mode_active = sel & (byte_q != 3'h0) & (opc_q == `SFES_OP_ACTIVE_STATUS);

  // Serial output: status byte on SCK falling edges, or live busy flag
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      SO    <= 1'b0;
      SO_OE <= 1'b0;
      out_q <= 8'h00;
    end else begin
      SO_OE <= mode_status | mode_active;
      if (mode_active) begin
        SO <= READY_BUSY_FLAG; // R15
      end else if (mode_status && sck_fall) begin
        if (bit_q == 3'h0) begin
          SO    <= status_one[7];
          out_q <= {status_one[6:0], 1'b0};
        end else begin
          SO    <= out_q[7];
          out_q <= {out_q[6:0], 1'b0};
        end
      end else if (!sel) begin
        SO <= 1'b0;
      end
    end
  end

endmodule

// File: tb/sfes_host.sv
// SPI host model that clocks command frames into the erase sequencer
`timescale 1ns/100ps
module sfes_host (
  // Clock
  input  wire clk,
  // SPI pins
  output reg  cs_n,
  output reg  sck,
  output reg  si
);
  // Mode 0 frame, 800 ns bit time, MSB first; keep leaves chip select low
  task frame(input [39:0] d, input integer n, input bit keep);
    integer i;
    begin
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 0; i < n; i = i + 1) begin
        si = d[39-i];
        repeat (4) @(negedge clk);
        sck = 1'b1;
        repeat (4) @(negedge clk);
        sck = 1'b0;
      end
      si = ~si;
      if (!keep) finish_frame();
    end
  endtask
  // Raise chip select and leave the bus quiet
  task finish_frame;
    begin
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      repeat (8) @(negedge clk);
    end
  endtask
  // Idle levels
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
endmodule

// File: tb/sfes_top_assertions.sv
// Concurrent checks on the erase sequencer ports
`timescale 1ns/100ps
module sfes_top_assertions (
  // Clock and reset
  input wire        CLK,
  input wire        RST,
  // Protection
  input wire [2:0]  BLOCK_PROTECT_FIELD,
  input wire        INDIVIDUAL_LOCK_SELECT,
  input wire        ANY_BLOCK_LOCKED,
  // Array side
  input wire        ERASE_FAIL,
  input wire [23:0] CMD_ADDR,
  input wire        ERASE_START,
  input wire [2:0]  ERASE_KIND,
  input wire [23:0] ERASE_BASE,
  input wire        ERASE_DONE,
  // Status
  input wire        READY_BUSY_FLAG,
  input wire        WRITE_ENABLE_LATCH,
  input wire        ERASE_ERROR_FLAG,
  input wire        PROGRAM_ERROR_FLAG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_start_busy: assert property (ERASE_START |-> READY_BUSY_FLAG && !WRITE_ENABLE_LATCH)
    else $error("start without busy or with latch set");
  chk_needs_latch: assert property ($rose(READY_BUSY_FLAG) |-> ERASE_START && $past(WRITE_ENABLE_LATCH))
    else $error("busy rose without latch");
  chk_start_pulse: assert property (ERASE_START |=> !ERASE_START)
    else $error("start pulse too long");
  chk_done_ends: assert property (ERASE_DONE |-> !READY_BUSY_FLAG && $past(READY_BUSY_FLAG))
    else $error("done without end of busy");
  chk_busy_until_done: assert property ($fell(READY_BUSY_FLAG) |-> ERASE_DONE)
    else $error("busy fell without done");
  chk_error_pair: assert property (ERASE_DONE |-> ERASE_ERROR_FLAG == $past(ERASE_FAIL)
    && PROGRAM_ERROR_FLAG == ERASE_ERROR_FLAG)
    else $error("error flags wrong at done");
  chk_page_base: assert property (ERASE_START && ERASE_KIND == 3'h0 |->
    ERASE_BASE == {4'h0, CMD_ADDR[19:8], 8'h00})
    else $error("page base wrong");
  chk_block_base: assert property (ERASE_START && ERASE_KIND inside {3'h1, 3'h2, 3'h3} |->
    ERASE_BASE == (CMD_ADDR & (ERASE_KIND == 3'h1 ? 24'hfff000 : ERASE_KIND == 3'h2 ? 24'hff8000 : 24'hff0000)))
    else $error("block base wrong");
  chk_chip_guard: assert property (ERASE_START && ERASE_KIND == 3'h4 |-> ERASE_BASE == 24'h0
    && BLOCK_PROTECT_FIELD == 3'h0 && !(INDIVIDUAL_LOCK_SELECT && ANY_BLOCK_LOCKED))
    else $error("chip erase under protection");
  chk_latch_busy: assert property (READY_BUSY_FLAG |-> !WRITE_ENABLE_LATCH)
    else $error("latch set while busy");
endmodule
bind sfes_top sfes_top_assertions sfes_top_assertions_inst (.CLK(CLK), .RST(RST),
  .BLOCK_PROTECT_FIELD(BLOCK_PROTECT_FIELD), .INDIVIDUAL_LOCK_SELECT(INDIVIDUAL_LOCK_SELECT),
  .ANY_BLOCK_LOCKED(ANY_BLOCK_LOCKED), .ERASE_FAIL(ERASE_FAIL), .CMD_ADDR(CMD_ADDR),
  .ERASE_START(ERASE_START), .ERASE_KIND(ERASE_KIND), .ERASE_BASE(ERASE_BASE), .ERASE_DONE(ERASE_DONE),
  .READY_BUSY_FLAG(READY_BUSY_FLAG), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
  .ERASE_ERROR_FLAG(ERASE_ERROR_FLAG), .PROGRAM_ERROR_FLAG(PROGRAM_ERROR_FLAG));

// File: tb/test_serial_flash_erase_sequencer.sv
// Self-checking bench for the erase sequencer
`timescale 1ns/100ps
module test_serial_flash_erase_sequencer;
  reg         clk, rst, fail_in, reg_prot, lock_sel, any_lock, started, prev;
  reg  [2:0]  bp;
  wire        cs_n, sck, si, so, so_oe, start, done, busy, write_enable_latch, ee, pe;
  wire [2:0]  kind;
  wire [23:0] base, caddr;
  integer     fails, check_count, busy_len, cyc, i;
  sfes_host sfes_host_inst (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
  sfes_top #(.PAGE_ERASE_CYCLES(32'd20), .BLOCK_ERASE_CYCLES(32'd40), .CHIP_ERASE_CYCLES(32'd200)) sfes_top_inst (
    .CLK(clk), .RST(rst), .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .SO_OE(so_oe),
    .BLOCK_PROTECT_FIELD(bp), .INDIVIDUAL_LOCK_SELECT(lock_sel), .ANY_BLOCK_LOCKED(any_lock),
    .REGION_PROTECTED(reg_prot), .ERASE_FAIL(fail_in), .CMD_ADDR(caddr), .ERASE_START(start),
    .ERASE_KIND(kind), .ERASE_BASE(base), .ERASE_DONE(done), .READY_BUSY_FLAG(busy),
    .WRITE_ENABLE_LATCH(write_enable_latch), .ERASE_ERROR_FLAG(ee), .PROGRAM_ERROR_FLAG(pe));
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Busy length, start capture and hang guard
  always @(negedge clk) begin
    cyc = cyc + 1;
    if (start) begin
      started = 1'b1;
      busy_len = 1;
    end else if (busy) busy_len = busy_len + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  task check(input string name, input logic [23:0] exp, input logic [23:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Latch set, erase frame, then wait out busy
  task erase(input [7:0] op, input integer n, input [2:0] k, input [23:0] b, input integer len);
    begin
      sfes_host_inst.frame({8'h06, 32'h0}, 8, 0);
      check("latch", 1, write_enable_latch);
      started = 1'b0;
      sfes_host_inst.frame({op, 24'habcdef, 8'h0}, n, 0);
      check("start", 1, started);
      check("kind", k, kind);
      check("base", b, base);
      check("latch", 0, write_enable_latch);
      for (i = 0; i < 1000 && busy; i = i + 1) @(negedge clk);
      check("busy time", len, busy_len);
      check("error", 0, ee);
      $display("Test erase %h done", op);
    end
  endtask
  // Refused erase: no launch, latch cleared
  task abort(input [7:0] op, input integer n, input [2:0] p, input [2:0] bpv);
    begin
      {reg_prot, lock_sel, any_lock} = p;
      bp = bpv;
      sfes_host_inst.frame({8'h06, 32'h0}, 8, 0);
      started = 1'b0;
      sfes_host_inst.frame({op, 24'h123456, 8'h0}, n, 0);
      check("aborted start", 0, started);
      check("aborted latch", 0, write_enable_latch);
      {reg_prot, lock_sel, any_lock, bp} = 6'h0;
      $display("Test abort %h done", op);
    end
  endtask
  // Chip erase with suspend ignored and live busy on serial out
  task t_active;
    begin
      fail_in = 1'b1;
      sfes_host_inst.frame({8'h06, 32'h0}, 8, 0);
      sfes_host_inst.frame({8'hc7, 32'h0}, 8, 0);
      sfes_host_inst.frame({8'h75, 32'h0}, 8, 0);
      sfes_host_inst.frame({8'h25, 32'h0}, 8, 1);
      // Serial out is registered, so it shows the busy flag of one cycle earlier
      for (i = 0; i < 1000 && busy; i = i + 1) begin
        prev = busy;
        @(negedge clk);
        check("live busy", {1'b1, prev}, {so_oe, so});
      end
      repeat (2) @(negedge clk);
      check("so low", 0, so);
      sfes_host_inst.finish_frame();
      check("chip time", 200, busy_len);
      check("errors", 2'b11, {ee, pe});
      fail_in = 1'b0;
      $display("Test active done");
    end
  endtask
  task complete_run;
    begin
      $display("Checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    {rst, fail_in, reg_prot, lock_sel, any_lock, started, bp} = 9'h100;
    {fails, check_count, busy_len, cyc} = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    sfes_host_inst.frame({8'h20, 24'habcdef, 8'h0}, 32, 0);
    check("no latch busy", 0, busy);
    erase(8'h81, 32, 3'h0, 24'h0bcd00, 20);
    erase(8'hdb, 32, 3'h0, 24'h0bcd00, 20);
    erase(8'h20, 32, 3'h1, 24'habc000, 40);
    erase(8'h52, 32, 3'h2, 24'hab8000, 40);
    erase(8'hd8, 40, 3'h3, 24'hab0000, 40);
    erase(8'h60, 8, 3'h4, 24'h000000, 200);
    abort(8'h20, 28, 3'h0, 3'h0);
    abort(8'h52, 24, 3'h0, 3'h0);
    abort(8'hd8, 32, 3'h4, 3'h0);
    abort(8'h60, 11, 3'h0, 3'h0);
    abort(8'h60, 8, 3'h0, 3'h2);
    abort(8'hc7, 8, 3'h3, 3'h0);
    t_active();
    complete_run();
  end
endmodule
